// ===== pkg/tts_pkg.sv
// constants and types for the temperature sensor register bank
package tts_pkg;
    // -------------------------------------------------------------
    // register pointers
    // -------------------------------------------------------------
    localparam logic [7:0] PTR_TEMP   = 8'h00;
    localparam logic [7:0] PTR_CTRL   = 8'h01;
    localparam logic [7:0] PTR_UPPER  = 8'h02;
    localparam logic [7:0] PTR_LOWER  = 8'h03;
    localparam logic [7:0] PTR_TEST_A = 8'h04;
    localparam logic [7:0] PTR_TEST_B = 8'h05;
    localparam logic [7:0] PTR_ADDR   = 8'h06;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] PTR_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [5:0] ADDR_DFLT = 6'h24;
    // -------------------------------------------------------------
    // control fields
    // -------------------------------------------------------------
    localparam int CTL_LOWBAT  = 7;
    localparam int CTL_CLRALM  = 6;
    localparam int CTL_RAW     = 5;
    localparam int CTL_CNT_HI  = 4;
    localparam int CTL_CNT_LO  = 3;
    localparam int CTL_INV     = 2;
    localparam int CTL_INTMODE = 1;
    localparam int CTL_STBY    = 0;
    // -------------------------------------------------------------
    // temperature word fields
    // -------------------------------------------------------------
    localparam int TW_FRESH  = 15;
    localparam int TW_LOWBAT = 14;
    localparam int TW_HYST   = 13;
    localparam int TW_HIGH   = 12;
    localparam int TW_LOW    = 11;
    // -------------------------------------------------------------
    // nonvolatile fields
    // -------------------------------------------------------------
    localparam int NV8_LOCK    = 0;
    localparam int NV9_ADDRLCK = 1;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int UPDATE_MS   = 250;
    localparam int UPDATE_CYC  = CLK_HZ / 1000 * UPDATE_MS;
    localparam int DIV_W       = 24;
    typedef enum logic {TTS_SEEK_HIGH = 1'b0, TTS_SEEK_LOW = 1'b1} tts_seek_t;
endpackage

// ===== hw/tts_regbank.sv
// register bank, limit compare and alarm logic of the sensor
//
// How it works
// [R01] new result sets bit 15; reading the temperature word clears it
// [R02] bit 14 shows supply below the selected threshold
// [R03] bit 13 sets at or above upper, clears at or below lower
// [R04] bit 12 is temperature at or above upper limit
// [R05] bit 11 is temperature at or below lower limit
// [R06] bits 10:0 hold signed temperature, 0.125 degree per step
// [R07] raw select presents the uncalibrated 12-bit code instead
// [R08] control bit 7 picks supply-low threshold, 0 is 2.4V, 1 is 2.2V
// [R09] control bit 6 forces flags 13:11 and alarm pin inactive
// [R10] control bits 4:3 set consecutive conversions before pin change
// [R11] field maps to 1,2,4,8; an in-limit conversion zeroes the count
// [R12] result updates every quarter second and drives the counting
// [R13] control bit 2 sets alarm pin polarity
// [R14] polarity 0: pin low when active, high when idle; 1 inverts
// [R15] control bit 1: 0 comparator mode, 1 interrupt mode
// [R16] interrupt mode: any read clears it; next fires on opposite limit
// [R17] control bit 0 selects standby
// [R18] limits use the 11-bit signed format, upper bits read zero
// [R19] limits load from nonvolatile bytes at power-on or chip enable
// [R20] pointer and control reset to 00h, shadow bytes copied
// [R21] lock bit in byte eight rejects further programming
// [R22] bus address uses byte nine when address-locked, else 100100
// [R23] address readback shows byte nine bits 7:2 and lock bit
// [R24] host leaves test registers 04h and 05h alone
// [R25] writes to read-only registers are ignored
`timescale 1ns/100ps
module tts_regbank #(
    parameter int UPDATE_CYCLES = tts_pkg::UPDATE_CYC
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        chip_enable,
    input  wire logic        address_select_pin,
    input  wire logic        vdd_below_2v4,
    input  wire logic        vdd_below_2v2,
    input  wire logic [10:0] sensor_temp,
    input  wire logic [11:0] raw_sensor_code,
    input  wire logic [7:0]  nvm_byte_six,
    input  wire logic [7:0]  nvm_byte_seven,
    input  wire logic [7:0]  nvm_byte_eight,
    input  wire logic [7:0]  nvm_byte_nine,
    input  wire logic        nvm_prog_req,
    output logic             nvm_prog_grant,
    input  wire logic        reg_ptr_wr,
    input  wire logic [7:0]  reg_ptr_in,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic [6:0]       bus_address,
    output logic             alarm_o,
    output logic             alarm_oe
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [1:0]          cs_s;
        logic [1:0]          a0_s;
        logic [1:0]          b24_s;
        logic [1:0]          b22_s;
        logic                cs_d;
        logic                load_pend;
        logic [7:0]          ptr;
        logic [7:0]          ctrl;
        logic [10:0]         up;
        logic [10:0]         lo;
        logic [7:0]          test_a;
        logic [7:0]          test_b;
        logic [7:0]          nvm9;
        logic [10:0]         temp;
        logic [11:0]         raw;
        logic                fresh;
        logic                hyst;
        logic                high;
        logic                low;
        logic [3:0]          cnt;
        logic                os;
        logic                irq;
        tts_pkg::tts_seek_t  seek;
        logic [tts_pkg::DIV_W-1:0] div;
        logic [15:0]         rdata;
        logic [6:0]          addr;
    } tts_state_t;

    tts_state_t st_r;
    tts_state_t st_nxt;
    logic [1:0] rst_q;
    logic       rst_n;
    logic       tick;
    logic       lowbat;
    logic       active;
    logic [15:0] temp_word;
    logic [3:0] need;

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // -------------------------------------------------------------
    // derived values
    // -------------------------------------------------------------
    assign tick = (st_r.div == tts_pkg::DIV_W'(UPDATE_CYCLES - 1))
                  && !st_r.ctrl[tts_pkg::CTL_STBY]; // see [R12] [R17]
    assign lowbat = st_r.ctrl[tts_pkg::CTL_LOWBAT] ? st_r.b22_s[1]
                                                  : st_r.b24_s[1]; // see [R08]
    assign need = 4'h1 << st_r.ctrl[tts_pkg::CTL_CNT_HI:tts_pkg::CTL_CNT_LO];
    assign temp_word = st_r.ctrl[tts_pkg::CTL_RAW] ? {4'h0, st_r.raw}
        : {st_r.fresh, lowbat, st_r.hyst, st_r.high, st_r.low,
           st_r.temp}; // see [R02] [R06] [R07]
    assign active = st_r.ctrl[tts_pkg::CTL_INTMODE] ? st_r.irq
                                                   : st_r.os; // see [R15]
    // open drain: enable pulls the pin low
    assign alarm_o  = 1'b0;
    assign alarm_oe = st_r.ctrl[tts_pkg::CTL_INV] ? ~active
                                                 : active; // see [R13] [R14]
    assign nvm_prog_grant = nvm_prog_req
                            && !nvm_byte_eight[tts_pkg::NV8_LOCK]; // see [R21]
    assign reg_rdata   = st_r.rdata;
    assign bus_address = st_r.addr;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        logic       hi;
        logic       lw;
        logic       hit;
        logic       look;
        logic [3:0] cnt1;
        hi = 1'b0;
        lw = 1'b0;
        hit = 1'b0;
        look = 1'b0;
        cnt1 = 4'h0;
        st_nxt = st_r;
        st_nxt.cs_s  = {st_r.cs_s[0], chip_enable};
        st_nxt.a0_s  = {st_r.a0_s[0], address_select_pin};
        st_nxt.b24_s = {st_r.b24_s[0], vdd_below_2v4};
        st_nxt.b22_s = {st_r.b22_s[0], vdd_below_2v2};
        st_nxt.cs_d  = st_r.cs_s[1];
        st_nxt.addr  = {st_r.nvm9[tts_pkg::NV9_ADDRLCK] ? st_r.nvm9[7:2]
                        : tts_pkg::ADDR_DFLT, st_r.a0_s[1]}; // see [R22]
        st_nxt.div = tick ? '0 : st_r.div + 1'b1;
        if (st_r.ctrl[tts_pkg::CTL_STBY]) begin
            st_nxt.div = '0;
        end
        // host access
        if (reg_ptr_wr) begin
            st_nxt.ptr = reg_ptr_in;
        end
        if (reg_wr) begin
            case (st_r.ptr)
                tts_pkg::PTR_CTRL:   st_nxt.ctrl = reg_wdata[7:0];
                tts_pkg::PTR_UPPER:  st_nxt.up = reg_wdata[10:0]; // see [R18]
                tts_pkg::PTR_LOWER:  st_nxt.lo = reg_wdata[10:0]; // see [R18]
                tts_pkg::PTR_TEST_A: st_nxt.test_a = reg_wdata[7:0];
                tts_pkg::PTR_TEST_B: st_nxt.test_b = reg_wdata[7:0];
                default: ; // see [R25]
            endcase
        end
        if (reg_rd) begin
            case (st_r.ptr)
                tts_pkg::PTR_TEMP:   st_nxt.rdata = temp_word;
                tts_pkg::PTR_CTRL:   st_nxt.rdata = {8'h00, st_r.ctrl};
                tts_pkg::PTR_UPPER:  st_nxt.rdata = {5'h00, st_r.up};
                tts_pkg::PTR_LOWER:  st_nxt.rdata = {5'h00, st_r.lo};
                tts_pkg::PTR_TEST_A: st_nxt.rdata = {8'h00, st_r.test_a};
                tts_pkg::PTR_TEST_B: st_nxt.rdata = {8'h00, st_r.test_b};
                tts_pkg::PTR_ADDR:   st_nxt.rdata = {8'h00, st_r.nvm9[7:2],
                    st_r.nvm9[tts_pkg::NV9_ADDRLCK], 1'b0}; // see [R23]
                default:             st_nxt.rdata = 16'h0000;
            endcase
            if (st_r.ptr == tts_pkg::PTR_TEMP) begin
                st_nxt.fresh = 1'b0; // see [R01]
            end
            if (st_r.ctrl[tts_pkg::CTL_INTMODE]) begin
                st_nxt.irq = 1'b0; // see [R16]
            end
        end
        if (st_r.ctrl[tts_pkg::CTL_STBY]
            && st_r.ctrl[tts_pkg::CTL_INTMODE]) begin
            st_nxt.irq = 1'b0;
        end
        // conversion update
        if (tick) begin
            st_nxt.temp  = sensor_temp;
            st_nxt.raw   = raw_sensor_code;
            st_nxt.fresh = 1'b1; // see [R01]
            hi = $signed(sensor_temp) >= $signed(st_r.up); // see [R04]
            lw = $signed(sensor_temp) <= $signed(st_r.lo); // see [R05]
            st_nxt.high = hi;
            st_nxt.low  = lw;
            if (hi) begin
                st_nxt.hyst = 1'b1; // see [R03]
            end else if (lw) begin
                st_nxt.hyst = 1'b0; // see [R03]
            end
            look = st_r.ctrl[tts_pkg::CTL_INTMODE] ? st_r.seek : st_r.os;
            hit  = look ? lw : hi;
            cnt1 = st_r.cnt + 4'h1;
            if (!hit) begin
                st_nxt.cnt = 4'h0; // see [R11]
            end else if (cnt1 >= need) begin
                st_nxt.cnt = 4'h0; // see [R10] [R11]
                if (st_r.ctrl[tts_pkg::CTL_INTMODE]) begin
                    st_nxt.irq = 1'b1; // see [R16]
                    st_nxt.seek = look ? tts_pkg::TTS_SEEK_HIGH
                                       : tts_pkg::TTS_SEEK_LOW;
                end else begin
                    st_nxt.os = ~st_r.os;
                end
            end else begin
                st_nxt.cnt = cnt1;
            end
        end
        if (st_r.ctrl[tts_pkg::CTL_CLRALM]) begin
            st_nxt.hyst = 1'b0; // see [R09]
            st_nxt.high = 1'b0;
            st_nxt.low  = 1'b0;
            st_nxt.os   = 1'b0;
            st_nxt.irq  = 1'b0;
            st_nxt.cnt  = 4'h0;
            st_nxt.seek = tts_pkg::TTS_SEEK_HIGH;
        end
        // defaults from nonvolatile bytes
        if (st_r.cs_s[1] && !st_r.cs_d) begin
            st_nxt.load_pend = 1'b1;
        end
        if (st_r.load_pend && st_r.cs_s[1]) begin
            st_nxt.load_pend = 1'b0;
            st_nxt.ptr  = tts_pkg::PTR_RST; // see [R20]
            st_nxt.ctrl = tts_pkg::CTRL_RST; // see [R20]
            st_nxt.nvm9 = nvm_byte_nine; // see [R20]
            st_nxt.lo = {nvm_byte_eight[7:5], nvm_byte_six}; // see [R19]
            st_nxt.up = {nvm_byte_eight[4:2], nvm_byte_seven}; // see [R19]
            st_nxt.os = 1'b0;
            st_nxt.irq = 1'b0;
            st_nxt.cnt = 4'h0;
            st_nxt.seek = tts_pkg::TTS_SEEK_HIGH;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.load_pend <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_fresh_set;
        @(posedge mclk) disable iff (!rst_n)
        tick && !st_r.ctrl[tts_pkg::CTL_CLRALM] |=> st_r.fresh;
    endproperty
    a_fresh_set: assert property (p_fresh_set) // see [R01]
        else $error("fresh flag not set by update");

    property p_fresh_clr;
        @(posedge mclk) disable iff (!rst_n)
        reg_rd && st_r.ptr == tts_pkg::PTR_TEMP && !tick
        && !st_r.ctrl[tts_pkg::CTL_RAW]
        |=> !st_r.fresh ##1 (!st_r.fresh || $past(tick));
    endproperty
    a_fresh_clr: assert property (p_fresh_clr) // see [R01]
        else $error("fresh flag not cleared by read");

    property p_high;
        @(posedge mclk) disable iff (!rst_n)
        tick && !st_r.ctrl[tts_pkg::CTL_CLRALM] |=> st_r.high ==
        ($signed($past(sensor_temp)) >= $signed($past(st_r.up)));
    endproperty
    a_high: assert property (p_high) // see [R04]
        else $error("high flag wrong after update");

    property p_low;
        @(posedge mclk) disable iff (!rst_n)
        tick && !st_r.ctrl[tts_pkg::CTL_CLRALM] |=> st_r.low ==
        ($signed($past(sensor_temp)) <= $signed($past(st_r.lo)));
    endproperty
    a_low: assert property (p_low) // see [R05]
        else $error("low flag wrong after update");

    property p_clear_alarm;
        @(posedge mclk) disable iff (!rst_n)
        st_r.ctrl[tts_pkg::CTL_CLRALM] ##1 st_r.ctrl[tts_pkg::CTL_CLRALM]
        |-> !st_r.hyst && !alarm_oe == !st_r.ctrl[tts_pkg::CTL_INV];
    endproperty
    a_clear_alarm: assert property (p_clear_alarm) // see [R09]
        else $error("alarm not forced inactive");

    property p_standby;
        @(posedge mclk) disable iff (!rst_n)
        st_r.ctrl[tts_pkg::CTL_STBY] |=> $stable(st_r.temp);
    endproperty
    a_standby: assert property (p_standby) // see [R17]
        else $error("result changed in standby");

    property p_lock;
        @(posedge mclk) disable iff (!rst_n)
        nvm_byte_eight[tts_pkg::NV8_LOCK] |-> !nvm_prog_grant;
    endproperty
    a_lock: assert property (p_lock) // see [R21]
        else $error("programming granted while locked");

    property p_ro_write;
        @(posedge mclk) disable iff (!rst_n)
        reg_wr && st_r.ptr == tts_pkg::PTR_TEMP && !tick
        |=> $stable(st_r.temp);
    endproperty
    a_ro_write: assert property (p_ro_write) // see [R25]
        else $error("read-only register changed by write");

    property p_irq_read;
        @(posedge mclk) disable iff (!rst_n)
        reg_rd && st_r.ctrl[tts_pkg::CTL_INTMODE] && !tick |=> !st_r.irq;
    endproperty
    a_irq_read: assert property (p_irq_read) // see [R16]
        else $error("interrupt not cleared by read");
endmodule

// ===== sim/tts_host.sv
// host model issuing pointer, write and read requests to the bank
`timescale 1ns/100ps
module tts_host (
    input  wire logic        mclk,
    input  wire logic [15:0] reg_rdata,
    output logic             reg_ptr_wr,
    output logic [7:0]       reg_ptr_in,
    output logic             reg_wr,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd
);
    initial begin
        reg_ptr_wr = 1'b0;
        reg_ptr_in = 8'h00;
        reg_wr     = 1'b0;
        reg_wdata  = 16'h0000;
        reg_rd     = 1'b0;
    end

    // ------------------------------------------------------------
    // access: pointer load, then one write or one read
    // ------------------------------------------------------------
    // callers never point at the test registers
    task automatic acc(input logic [7:0] p, input logic w,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        reg_ptr_wr <= 1'b1;
        reg_ptr_in <= p;
        @(posedge mclk);
        reg_ptr_wr <= 1'b0;
        reg_ptr_in <= ~p;
        reg_wr     <= w;
        reg_rd     <= !w;
        reg_wdata  <= d;
        @(posedge mclk);
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b0;
        reg_wdata  <= ~d;
        @(posedge mclk);
        #1 q = reg_rdata;
    endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the sensor register bank
`timescale 1ns/100ps
module tb;
    logic        mclk;
    logic        arst_n;
    logic        chip_enable;
    logic        address_select_pin;
    logic        vdd_below_2v4;
    logic        vdd_below_2v2;
    logic [10:0] sensor_temp;
    logic [11:0] raw_sensor_code;
    logic [7:0]  nvm_byte_six;
    logic [7:0]  nvm_byte_seven;
    logic [7:0]  nvm_byte_eight;
    logic [7:0]  nvm_byte_nine;
    logic        nvm_prog_req;
    logic        nvm_prog_grant;
    logic        reg_ptr_wr;
    logic [7:0]  reg_ptr_in;
    logic        reg_wr;
    logic [15:0] reg_wdata;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [6:0]  bus_address;
    logic        alarm_o;
    logic        alarm_oe;
    logic [15:0] q;
    logic [10:0] up_v;
    logic [10:0] lo_v;
    int          err_count;
    int          checks_done;
    localparam logic [54:0] TV = {11'h3E8, 11'h7FC, 11'h004,
                                  11'h050, 11'h0C8};
    localparam logic [4:0]  HV = 5'b10011;

    tts_host host (.mclk, .reg_rdata, .reg_ptr_wr, .reg_ptr_in, .reg_wr,
                   .reg_wdata, .reg_rd);
    tts_regbank #(.UPDATE_CYCLES(20)) dut (
        .mclk, .arst_n, .chip_enable, .address_select_pin, .vdd_below_2v4,
        .vdd_below_2v2, .sensor_temp, .raw_sensor_code, .nvm_byte_six,
        .nvm_byte_seven, .nvm_byte_eight, .nvm_byte_nine, .nvm_prog_req,
        .nvm_prog_grant, .reg_ptr_wr, .reg_ptr_in, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .bus_address, .alarm_o, .alarm_oe);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        logic [15:0] x;
        host.acc(p, 1'b1, d, x);
    endtask
    task automatic rd(input logic [7:0] p);
        host.acc(p, 1'b0, 16'h0000, q);
    endtask
    task automatic chk(input string n, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic pin(input logic e);
        #1;
        chk("alarm_o", {15'h0000, alarm_o}, 16'h0000);
        chk("alarm_oe", {15'h0000, alarm_oe}, {15'h0000, e});
    endtask
    task automatic setw(input logic [10:0] t, input int n);
        @(posedge mclk);
        sensor_temp <= t;
        cyc(n);
    endtask
    function automatic logic [15:0] ew(input logic lb, hy,
                                       input logic [10:0] t);
        return {1'b1, lb, hy, $signed(t) >= $signed(up_v),
                $signed(t) <= $signed(lo_v), t};
    endfunction
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_nv;
        up_v = {nvm_byte_eight[4:2], nvm_byte_seven};
        lo_v = {nvm_byte_eight[7:5], nvm_byte_six};
        rd(tts_pkg::PTR_CTRL);
        chk("control", q, 16'h0000);
        rd(tts_pkg::PTR_UPPER);
        chk("upper", q, {5'h00, up_v});
        rd(tts_pkg::PTR_LOWER);
        chk("lower", q, {5'h00, lo_v});
        wr(tts_pkg::PTR_ADDR, 16'h0000);
        rd(tts_pkg::PTR_ADDR);
        chk("readback", q,
            {8'h00, nvm_byte_nine[7:1], 1'b0});
        chk("grant", {15'h0000, nvm_prog_grant},
            {15'h0000, !nvm_byte_eight[0]});
        chk("address", {9'h000, bus_address}, {9'h000, (nvm_byte_nine[1] ?
            nvm_byte_nine[7:2] : 6'h24), address_select_pin});
    endtask
    task automatic t_flags;
        logic [10:0] tw;
        wr(tts_pkg::PTR_TEMP, 16'hFFFF);
        for (int i = 0; i < 5; i++) begin
            tw = TV[i*11 +: 11];
            setw(tw, 45);
            rd(tts_pkg::PTR_TEMP);
            chk("temp", q, ew(1'b1, HV[i], tw));
            pin(HV[i]);
        end
    endtask
    task automatic t_ctrl;
        wr(tts_pkg::PTR_CTRL, 16'h0080);
        cyc(45);
        rd(tts_pkg::PTR_TEMP);
        chk("lowbat", q, ew(1'b0, 1'b1, 11'h3E8));
        rd(tts_pkg::PTR_CTRL);
        chk("control", q, 16'h0080);
        wr(tts_pkg::PTR_CTRL, 16'h0020);
        cyc(45);
        rd(tts_pkg::PTR_TEMP);
        chk("raw", q, {4'h0, raw_sensor_code});
        wr(tts_pkg::PTR_CTRL, 16'h0040);
        cyc(45);
        rd(tts_pkg::PTR_TEMP);
        chk("cleared", q, 16'hC3E8);
        pin(1'b0);
        wr(tts_pkg::PTR_CTRL, 16'h0004);
        cyc(45);
        pin(1'b0);
        setw(11'h004, 45);
        pin(1'b1);
        wr(tts_pkg::PTR_CTRL, 16'h0000);
    endtask
    task automatic t_count;
        wr(tts_pkg::PTR_CTRL, 16'h0018);
        setw(11'h3E8, 120);
        pin(1'b0);
        cyc(90);
        pin(1'b1);
        setw(11'h7FC, 100);
        setw(11'h050, 40);
        setw(11'h7FC, 120);
        pin(1'b1);
        cyc(100);
        pin(1'b0);
    endtask
    task automatic t_irq;
        wr(tts_pkg::PTR_CTRL, 16'h0042);
        wr(tts_pkg::PTR_CTRL, 16'h0002);
        setw(11'h050, 45);
        pin(1'b0);
        setw(11'h3E8, 45);
        pin(1'b1);
        rd(tts_pkg::PTR_CTRL);
        pin(1'b0);
        cyc(45);
        pin(1'b0);
        setw(11'h7FC, 45);
        pin(1'b1);
        rd(tts_pkg::PTR_UPPER);
        pin(1'b0);
        setw(11'h3E8, 45);
        wr(tts_pkg::PTR_CTRL, 16'h0003);
        pin(1'b0);
        rd(tts_pkg::PTR_TEMP);
        cyc(60);
        rd(tts_pkg::PTR_TEMP);
        chk("fresh", {15'h0000, q[15]}, 16'h0000);
        wr(tts_pkg::PTR_CTRL, 16'h0000);
        cyc(45);
        rd(tts_pkg::PTR_TEMP);
        chk("fresh", {15'h0000, q[15]}, 16'h0001);
    endtask
    task automatic t_reload;
        wr(tts_pkg::PTR_UPPER, 16'hFFFF);
        rd(tts_pkg::PTR_UPPER);
        chk("upper", q, 16'h07FF);
        wr(tts_pkg::PTR_CTRL, 16'h009C);
        @(posedge mclk);
        chip_enable <= 1'b0;
        nvm_byte_six <= 8'h3C;
        nvm_byte_seven <= 8'h10;
        nvm_byte_eight <= 8'hA5;
        nvm_byte_nine <= 8'h50;
        address_select_pin <= 1'b0;
        cyc(5);
        chip_enable <= 1'b1;
        cyc(10);
        t_nv;
    endtask

    initial begin
        arst_n = 1'b0;
        chip_enable = 1'b1;
        address_select_pin = 1'b1;
        vdd_below_2v4 = 1'b1;
        vdd_below_2v2 = 1'b0;
        sensor_temp = 11'h050;
        raw_sensor_code = 12'hA5C;
        nvm_byte_six = 8'h04;
        nvm_byte_seven = 8'hC8;
        nvm_byte_eight = 8'h00;
        nvm_byte_nine = 8'hB2;
        nvm_prog_req = 1'b1;
        err_count = 0;
        checks_done = 0;
        cyc(10);
        arst_n <= 1'b1;
        cyc(10);
        t_nv;
        t_flags;
        t_ctrl;
        t_count;
        t_irq;
        t_reload;
        complete_run;
    end

    initial begin
        #400000;
        err_count++;
        complete_run;
    end
endmodule
